// ==== logic/cfr_pkg.sv ====
// package: constants and types for the cpu flags, register file and stack block
package cfr_pkg;
  localparam logic [15:0] CFR_STATUS_DADDR = 16'h005F;
  localparam logic [15:0] CFR_SPL_DADDR    = 16'h005D;
  localparam logic [15:0] CFR_SPH_DADDR    = 16'h005E;
  localparam logic [15:0] CFR_IO_OFFSET    = 16'h0020;
  localparam logic [15:0] CFR_GPR_LAST     = 16'h001F;
  localparam logic [7:0]  CFR_STATUS_RST   = 8'h00;
  localparam logic [15:0] CFR_SP_RST       = 16'h04FF;
  localparam logic [15:0] CFR_SP_MASK      = 16'h07FF;
  localparam logic [4:0]  CFR_PTR_X        = 5'h1A;
  localparam logic [4:0]  CFR_PTR_Y        = 5'h1C;
  localparam logic [4:0]  CFR_PTR_Z        = 5'h1E;
  localparam int          CFR_FLG_I = 7;
  localparam int          CFR_FLG_T = 6;
  localparam int          CFR_FLG_H = 5;
  localparam int          CFR_FLG_S = 4;
  localparam int          CFR_FLG_V = 3;
  localparam int          CFR_FLG_N = 2;
  localparam int          CFR_FLG_Z = 1;
  localparam int          CFR_FLG_C = 0;

  typedef enum logic [1:0] {
    CFR_WB_NONE = 2'h0,
    CFR_WB_B8   = 2'h1,
    CFR_WB_W16  = 2'h2
  } cfr_wb_t;

  typedef enum logic [2:0] {
    CFR_SP_HOLD   = 3'h0,
    CFR_SP_PUSH   = 3'h1,
    CFR_SP_POP    = 3'h2,
    CFR_SP_CALL   = 3'h3,
    CFR_SP_RET    = 3'h4,
    CFR_SP_IRQ_EXIT_OP   = 3'h5,
    CFR_SP_IRQ    = 3'h6
  } cfr_spop_t;

  typedef enum logic [1:0] {
    CFR_PM_DISP = 2'h0,
    CFR_PM_INC  = 2'h1,
    CFR_PM_DEC  = 2'h2
  } cfr_pmode_t;

  // alu result and flag sources from the datapath
  typedef struct packed {
    logic       valid;
    logic [7:0] result;
    logic       carry;
    logic       half;
    logic       ovf;
    logic       upd_h;
    logic       upd_v;
    logic       upd_c;
  } cfr_alu_t;

  // data-space access from load/store or io ops
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        io;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cfr_mem_t;
endpackage

// ==== logic/cfr_gpr_mem.sv ====
// general register storage with registered dual read and byte/word write
`timescale 1ns/1ps
module cfr_gpr_mem
  import cfr_pkg::*;
#(
  parameter int N_REGS = 32
) (
  input  wire logic                      CLK,
  input  wire logic                      RSTN,
  input  wire logic                      ce,
  input  wire logic [$clog2(N_REGS)-1:0] ra_a,
  input  wire logic [$clog2(N_REGS)-1:0] ra_b,
  output logic      [7:0]                rd_a,
  output logic      [7:0]                rd_b,
  output logic      [15:0]               rd_w,
  input  wire logic                      we_lo,
  input  wire logic                      we_hi,
  input  wire logic [$clog2(N_REGS)-1:0] wa,
  input  wire logic [15:0]               wd,
  output logic      [15:0]               ptr_x,
  output logic      [15:0]               ptr_y,
  output logic      [15:0]               ptr_z
);
  localparam int AW = $clog2(N_REGS);
  logic [7:0]    mem_reg [N_REGS];
  logic [AW-1:0] wa_hi;

  assign wa_hi = wa | AW'(1);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < N_REGS; i++) mem_reg[i] <= 8'h00;
    end else if (ce) begin
      if (we_lo) mem_reg[wa] <= wd[7:0];
      if (we_hi) mem_reg[wa_hi] <= wd[15:8];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_a <= 8'h00;
      rd_b <= 8'h00;
      rd_w <= 16'h0000;
    end else if (ce) begin
      rd_a <= mem_reg[ra_a];
      rd_b <= mem_reg[ra_b];
      rd_w <= {mem_reg[ra_a | AW'(1)], mem_reg[ra_a & ~AW'(1)]};
    end
  end

  // low byte even, high byte odd
  assign ptr_x = {mem_reg[AW'(CFR_PTR_X) + AW'(1)], mem_reg[AW'(CFR_PTR_X)]};
  assign ptr_y = {mem_reg[AW'(CFR_PTR_Y) + AW'(1)], mem_reg[AW'(CFR_PTR_Y)]};
  assign ptr_z = {mem_reg[AW'(CFR_PTR_Z) + AW'(1)], mem_reg[AW'(CFR_PTR_Z)]};
endmodule

// ==== logic/cfr_core.sv ====
// flag register, register file wrapper, pointer addressing and stack pointer
`timescale 1ns/1ps
module cfr_core
  import cfr_pkg::*;
#(
  parameter int N_REGS = 32
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  // operand reads
  input  wire logic [4:0]  RD_SEL_A,
  input  wire logic [4:0]  RD_SEL_B,
  output logic      [7:0]  RD_DATA_A,
  output logic      [7:0]  RD_DATA_B,
  output logic      [15:0] RD_DATA_W,
  // result write back
  input  cfr_wb_t          WB_KIND,
  input  wire logic [4:0]  WB_SEL,
  input  wire logic [15:0] WB_DATA,
  // alu flags
  input  cfr_alu_t         ALU,
  // flag ops
  input  wire logic        IRQ_ENABLE_OP,
  input  wire logic        IRQ_DISABLE_OP,
  input  wire logic        BIT_TO_COPYFLAG,
  input  wire logic        COPYFLAG_TO_BIT,
  input  wire logic [2:0]  BIT_SEL,
  // stack
  input  cfr_spop_t        SP_OP,
  output logic      [15:0] SP_VALUE,
  // interrupt gating
  input  wire logic        IRQ_REQ,
  output logic             IRQ_GRANT,
  // pointer addressing
  input  wire logic        PTR_REQ,
  input  wire logic [1:0]  PTR_SEL,
  input  cfr_pmode_t       PTR_MODE,
  input  wire logic [5:0]  PTR_DISP,
  output logic      [15:0] PTR_ADDR,
  // data-space access
  input  cfr_mem_t         MEM,
  output logic      [7:0]  MEM_RDATA,
  output logic             MEM_HIT,
  output logic      [7:0]  STATUS
);
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic [7:0]  mem_rdata_reg;
  logic        mem_hit_reg;
  logic [15:0] daddr;
  logic        hit_status;
  logic        hit_spl;
  logic        hit_sph;
  logic        hit_gpr;
  logic        hit_gpr_d;
  logic [15:0] ptr_x;
  logic [15:0] ptr_y;
  logic [15:0] ptr_z;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_upd;
  logic [4:0]  ptr_base;
  logic [4:0]  g_ra_a;
  logic        g_we_lo;
  logic        g_we_hi;
  logic [4:0]  g_wa;
  logic [15:0] g_wd;
  logic        ptr_wb;
  logic        copy_wb;
  logic [7:0]  copy_val;

  // io accesses are rebased to data space
  assign daddr = MEM.io ? (MEM.addr + CFR_IO_OFFSET) : MEM.addr;

  // status decode at its data address
  assign hit_status = (daddr == CFR_STATUS_DADDR);
  assign hit_spl = (daddr == CFR_SPL_DADDR);
  assign hit_sph = (daddr == CFR_SPH_DADDR);
  // low data space maps to general registers
  assign hit_gpr = !MEM.io && (MEM.addr <= CFR_GPR_LAST);

  // pointer selection and its automatic update
  // codes 2 and 3 both pick the third pointer, so no select is illegal
  always_comb begin
    unique case (PTR_SEL)
      2'h0:    begin ptr_cur = ptr_x; ptr_base = CFR_PTR_X; end
      2'h1:    begin ptr_cur = ptr_y; ptr_base = CFR_PTR_Y; end
      default: begin ptr_cur = ptr_z; ptr_base = CFR_PTR_Z; end
    endcase
  end

  always_comb begin
    ptr_upd  = ptr_cur;
    PTR_ADDR = ptr_cur;
    unique case (PTR_MODE)
      CFR_PM_INC: ptr_upd = ptr_cur + 16'h0001;
      CFR_PM_DEC: begin
        ptr_upd  = ptr_cur - 16'h0001;
        PTR_ADDR = ptr_upd;
      end
      default:    PTR_ADDR = ptr_cur + {10'h000, PTR_DISP};
    endcase
  end
  assign ptr_wb = PTR_REQ && (PTR_MODE != CFR_PM_DISP);

  // copy flag into a register bit
  always_comb begin
    copy_val = RD_DATA_A;
    copy_val[BIT_SEL] = status_reg[CFR_FLG_T];
  end
  assign copy_wb = COPYFLAG_TO_BIT;

  // write port arbitration: pointer update beats memory store beats alu
  always_comb begin
    g_we_lo = 1'b0;
    g_we_hi = 1'b0;
    g_wa    = WB_SEL;
    g_wd    = WB_DATA;
    if (ptr_wb) begin
      g_we_lo = 1'b1;
      g_we_hi = 1'b1;
      g_wa    = ptr_base;
      g_wd    = ptr_upd;
    end else if (MEM.wr && hit_gpr) begin
      g_we_lo = 1'b1;
      g_wa    = MEM.addr[4:0];
      g_wd    = {8'h00, MEM.wdata};
    end else if (copy_wb) begin
      g_we_lo = 1'b1;
      g_wa    = RD_SEL_A;
      g_wd    = {8'h00, copy_val};
    end else begin
      // 8-bit or 16-bit result write back
      g_we_lo = (WB_KIND != CFR_WB_NONE);
      g_we_hi = (WB_KIND == CFR_WB_W16);
    end
  end

  // memory reads of the register range reuse port a
  assign g_ra_a = (MEM.rd && hit_gpr) ? MEM.addr[4:0] : RD_SEL_A;

  cfr_gpr_mem #(
    .N_REGS (N_REGS)
  ) u_gpr (
    .CLK   (CLK),
    .RSTN  (RSTN),
    .ce    (CE),
    .ra_a  (g_ra_a),
    .ra_b  (RD_SEL_B),
    .rd_a  (RD_DATA_A),
    .rd_b  (RD_DATA_B),
    .rd_w  (RD_DATA_W),
    .we_lo (g_we_lo),
    .we_hi (g_we_hi),
    .wa    (g_wa),
    .wd    (g_wd),
    .ptr_x (ptr_x),
    .ptr_y (ptr_y),
    .ptr_z (ptr_z)
  );

  // flag next state; later assignments take priority
  always_comb begin
    status_next = status_reg;
    if (ALU.valid) begin
      // negative and zero from result, carry from the alu carry when upd_c is set
      status_next[CFR_FLG_N] = ALU.result[7];
      status_next[CFR_FLG_Z] = (ALU.result == 8'h00);
      if (ALU.upd_c) status_next[CFR_FLG_C] = ALU.carry;
      // half carry where the op defines it
      if (ALU.upd_h) status_next[CFR_FLG_H] = ALU.half;
      if (ALU.upd_v) status_next[CFR_FLG_V] = ALU.ovf;
      status_next[CFR_FLG_S] = status_next[CFR_FLG_N] ^ status_next[CFR_FLG_V];
    end
    if (BIT_TO_COPYFLAG) status_next[CFR_FLG_T] = RD_DATA_A[BIT_SEL];
    // direct write of the whole register
    if (MEM.wr && hit_status) status_next = MEM.wdata;
    if (IRQ_ENABLE_OP) status_next[CFR_FLG_I] = 1'b1;
    if (IRQ_DISABLE_OP) status_next[CFR_FLG_I] = 1'b0;
    // exit sets, entry clears; entry wins as it is the newer event
    if (SP_OP == CFR_SP_IRQ_EXIT_OP) status_next[CFR_FLG_I] = 1'b1;
    if (IRQ_GRANT) status_next[CFR_FLG_I] = 1'b0;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) status_reg <= CFR_STATUS_RST;
    else if (CE) status_reg <= status_next;
  end

  assign IRQ_GRANT = IRQ_REQ && status_reg[CFR_FLG_I] && !IRQ_DISABLE_OP;
  // flags are not saved on entry; software keeps them
  assign STATUS = status_reg;

  // stack pointer next value
  always_comb begin
    sp_next = sp_reg;
    unique case (SP_OP)
      // push stores then decrements by one
      CFR_SP_PUSH: sp_next = sp_reg - 16'h0001;
      CFR_SP_CALL: sp_next = sp_reg - 16'h0002;
      // pop plus one, returns plus two
      CFR_SP_POP:  sp_next = sp_reg + 16'h0001;
      CFR_SP_RET:  sp_next = sp_reg + 16'h0002;
      CFR_SP_IRQ_EXIT_OP: sp_next = sp_reg + 16'h0002;
      default:     sp_next = sp_reg;
    endcase
    // interrupt entry also pushes two bytes
    if (IRQ_GRANT) sp_next = sp_reg - 16'h0002;
    if (MEM.wr && hit_spl) sp_next = {sp_reg[15:8], MEM.wdata};
    if (MEM.wr && hit_sph) sp_next = {MEM.wdata, sp_reg[7:0]};
    sp_next = sp_next & CFR_SP_MASK;
  end

  // starts at the last internal sram address
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) sp_reg <= CFR_SP_RST;
    else if (CE) sp_reg <= sp_next;
  end
  assign SP_VALUE = sp_reg;

  // registered read data for non-register data-space hits
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mem_rdata_reg <= 8'h00;
      mem_hit_reg   <= 1'b0;
    end else if (CE) begin
      mem_hit_reg   <= MEM.rd && (hit_status || hit_spl || hit_sph || hit_gpr);
      mem_rdata_reg <= hit_status ? status_reg :
                       hit_spl    ? sp_reg[7:0] :
                       hit_sph    ? sp_reg[15:8] : 8'h00;
    end
  end
  // register range reads come back on port a
  assign MEM_RDATA = hit_gpr_d ? RD_DATA_A : mem_rdata_reg;
  assign MEM_HIT   = mem_hit_reg;

  // remembers that the pending read came from the register range
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) hit_gpr_d <= 1'b0;
    else if (CE) hit_gpr_d <= MEM.rd && hit_gpr;
  end

  // assertions
  a_sign_relation: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && ALU.valid && !MEM.wr |=> STATUS[CFR_FLG_S] == (STATUS[CFR_FLG_N] ^ STATUS[CFR_FLG_V]))
    else $error("sign flag not n xor v");
  a_gate_enable: assert property (@(posedge CLK) disable iff (!RSTN)
    !STATUS[CFR_FLG_I] |-> !IRQ_GRANT)
    else $error("interrupt granted while disabled");
  a_entry_clear: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && IRQ_GRANT |=> !STATUS[CFR_FLG_I])
    else $error("enable not cleared on entry");
  a_entry_sp: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && IRQ_GRANT && !(MEM.wr && (hit_spl || hit_sph))
    |=> SP_VALUE == ((($past(SP_VALUE)) - 16'h0002) & CFR_SP_MASK))
    else $error("entry did not drop sp by two");
  a_push_sp: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && SP_OP == CFR_SP_PUSH && !IRQ_GRANT && !MEM.wr
    |=> SP_VALUE == (($past(SP_VALUE) - 16'h0001) & CFR_SP_MASK))
    else $error("push did not drop sp by one");
  a_ret_sp: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && SP_OP == CFR_SP_RET && !IRQ_GRANT && !MEM.wr
    |=> SP_VALUE == (($past(SP_VALUE) + 16'h0002) & CFR_SP_MASK))
    else $error("return did not raise sp by two");
  a_sp_upper: assert property (@(posedge CLK) disable iff (!RSTN)
    SP_VALUE[15:11] == 5'h00)
    else $error("sp upper bits set");
  a_zero_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && ALU.valid && !MEM.wr |=> STATUS[CFR_FLG_Z] == ($past(ALU.result) == 8'h00))
    else $error("zero flag wrong");
  a_copy_store: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && BIT_TO_COPYFLAG && !MEM.wr |=> STATUS[CFR_FLG_T] == $past(RD_DATA_A[BIT_SEL]))
    else $error("copy flag not loaded");
  a_enable_op: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && IRQ_ENABLE_OP && !IRQ_DISABLE_OP && !IRQ_GRANT |=> STATUS[CFR_FLG_I])
    else $error("enable op had no effect");
  a_disable_op: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && IRQ_DISABLE_OP && SP_OP != CFR_SP_IRQ_EXIT_OP |=> !STATUS[CFR_FLG_I])
    else $error("disable op had no effect");
  a_disable_gate: assert property (@(posedge CLK) disable iff (!RSTN)
    IRQ_DISABLE_OP |-> !IRQ_GRANT)
    else $error("interrupt granted beside disable op");
  a_exit_set: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && SP_OP == CFR_SP_IRQ_EXIT_OP && !IRQ_GRANT |=> STATUS[CFR_FLG_I])
    else $error("enable not set on interrupt exit");
  a_status_write: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && MEM.wr && hit_status && !IRQ_ENABLE_OP && !IRQ_DISABLE_OP
    && SP_OP != CFR_SP_IRQ_EXIT_OP && !IRQ_GRANT |=> STATUS == $past(MEM.wdata))
    else $error("status write lost");
  a_carry_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && ALU.valid && ALU.upd_c && !MEM.wr |=> STATUS[CFR_FLG_C] == $past(ALU.carry))
    else $error("carry flag wrong");
  a_negative_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && ALU.valid && !MEM.wr |=> STATUS[CFR_FLG_N] == $past(ALU.result[7]))
    else $error("negative flag wrong");
  a_half_carry: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && ALU.valid && ALU.upd_h && !MEM.wr |=> STATUS[CFR_FLG_H] == $past(ALU.half))
    else $error("half carry flag wrong");
  a_overflow_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && ALU.valid && ALU.upd_v && !MEM.wr |=> STATUS[CFR_FLG_V] == $past(ALU.ovf))
    else $error("overflow flag wrong");
  a_pop_sp: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && SP_OP == CFR_SP_POP && !IRQ_GRANT && !MEM.wr
    |=> SP_VALUE == (($past(SP_VALUE) + 16'h0001) & CFR_SP_MASK))
    else $error("pop did not raise sp by one");
  a_exit_sp: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && SP_OP == CFR_SP_IRQ_EXIT_OP && !IRQ_GRANT && !MEM.wr
    |=> SP_VALUE == (($past(SP_VALUE) + 16'h0002) & CFR_SP_MASK))
    else $error("interrupt exit did not raise sp by two");
  a_call_sp: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && SP_OP == CFR_SP_CALL && !IRQ_GRANT && !MEM.wr
    |=> SP_VALUE == (($past(SP_VALUE) - 16'h0002) & CFR_SP_MASK))
    else $error("call did not drop sp by two");
  a_io_rebase: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && MEM.rd && MEM.io && MEM.addr == (CFR_STATUS_DADDR - CFR_IO_OFFSET)
    |=> MEM_HIT && MEM_RDATA == $past(STATUS))
    else $error("io status read missed");
  a_gpr_read: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && MEM.rd && hit_gpr |=> MEM_HIT)
    else $error("register range read not acknowledged");
  a_ptr_inc: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && PTR_REQ && PTR_MODE == CFR_PM_INC && PTR_SEL == 2'h0
    |=> ptr_x == $past(ptr_x) + 16'h0001)
    else $error("pointer not incremented");
  a_ptr_dec: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && PTR_REQ && PTR_MODE == CFR_PM_DEC && PTR_SEL == 2'h0
    |-> PTR_ADDR == ptr_x - 16'h0001)
    else $error("pre-decrement address wrong");
  // nothing may move while the clock enable is low
  a_hold_frozen: assert property (@(posedge CLK) disable iff (!RSTN) // clock enable hold
    !CE |=> $stable(STATUS) && $stable(SP_VALUE) && $stable(MEM_HIT))
    else $error("state moved with clock enable low");
endmodule

// ==== tb/cfr_alu_model.sv ====
// partner alu model: adds two operands and reports the flag sources
`timescale 1ns/1ps
module cfr_alu_model
  import cfr_pkg::*;
(
  input  wire logic       en,
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  output cfr_alu_t        alu
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic       ovf;

  assign sum = {1'b0, op_a} + {1'b0, op_b};
  assign nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
  // like signs in, other sign out
  assign ovf = (op_a[7] == op_b[7]) && (sum[7] != op_a[7]);
  assign alu = {en, sum[7:0], sum[8], nib[4], ovf, en, en, en};
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the flags, register file and stack block
`timescale 1ns/1ps
module testbench
  import cfr_pkg::*;
;
  logic       clk, rstn, ce, alu_en, ei, di, t_in, t_out, irq_req, grant, ptr_req, mem_hit;
  logic [4:0] sel_a, sel_b, wb_sel;
  logic [7:0] rd_a, rd_b, op_a, op_b, mem_rdata, status;
  logic [15:0] rd_w, wb_data, sp, ptr_addr;
  logic [2:0] bit_sel;
  logic [1:0] ptr_sel;
  logic [5:0] ptr_disp;
  cfr_wb_t    wb_kind;
  cfr_alu_t   alu;
  cfr_spop_t  sp_op;
  cfr_pmode_t ptr_mode;
  cfr_mem_t   mem;
  int         num_errors, check_count;

  cfr_alu_model i_cfr_alu_model (.en(alu_en), .op_a(op_a), .op_b(op_b), .alu(alu));

  cfr_core i_cfr_core (
    .CLK(clk), .RSTN(rstn), .CE(ce), .RD_SEL_A(sel_a), .RD_SEL_B(sel_b),
    .RD_DATA_A(rd_a), .RD_DATA_B(rd_b), .RD_DATA_W(rd_w), .WB_KIND(wb_kind),
    .WB_SEL(wb_sel), .WB_DATA(wb_data), .ALU(alu), .IRQ_ENABLE_OP(ei),
    .IRQ_DISABLE_OP(di), .BIT_TO_COPYFLAG(t_in), .COPYFLAG_TO_BIT(t_out),
    .BIT_SEL(bit_sel), .SP_OP(sp_op), .SP_VALUE(sp), .IRQ_REQ(irq_req),
    .IRQ_GRANT(grant), .PTR_REQ(ptr_req), .PTR_SEL(ptr_sel), .PTR_MODE(ptr_mode),
    .PTR_DISP(ptr_disp), .PTR_ADDR(ptr_addr), .MEM(mem), .MEM_RDATA(mem_rdata),
    .MEM_HIT(mem_hit), .STATUS(status)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // pulses drop back here so no request is taken twice
  task idle();
    wb_kind = CFR_WB_NONE;
    alu_en = 1'b0;
    ei = 1'b0;
    di = 1'b0;
    t_in = 1'b0;
    t_out = 1'b0;
    sp_op = CFR_SP_HOLD;
    irq_req = 1'b0;
    ptr_req = 1'b0;
    ptr_mode = CFR_PM_DISP;
    mem = '0;
  endtask

  task tick();
    @(posedge clk);
    @(negedge clk);
    idle();
  endtask

  task mem_wr(input logic io, input logic [15:0] a, input logic [7:0] d);
    mem = {1'b0, 1'b1, io, a, d};
    tick();
  endtask

  task mem_rd(input logic io, input logic [15:0] a, input logic [7:0] exp, input logic hit);
    mem = {1'b1, 1'b0, io, a, 8'h00};
    tick();
    chk("mem_hit", mem_hit, hit);
    if (hit)
      chk("mem_rdata", mem_rdata, exp);
  endtask

  task sp_step(input cfr_spop_t op, input logic [15:0] exp);
    sp_op = op;
    tick();
    chk("sp", sp, exp);
  endtask

  task finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #40000;
    num_errors++;
    finish_test();
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    rstn = 1'b0;
    ce = 1'b1;
    {sel_a, sel_b, wb_sel, wb_data, op_a, op_b, bit_sel, ptr_sel, ptr_disp} = '0;
    idle();
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    chk("status", status, 8'h00);
    chk("sp", sp, CFR_SP_RST);
    mem_wr(0, 16'h005F, 8'h7E);
    chk("status", status, 8'h7E);
    mem_rd(1, 16'h003F, 8'h7E, 1);
    mem_wr(1, 16'h003F, 8'h00);
    chk("status", status, 8'h00);
    mem_rd(0, 16'h0040, 8'h00, 0);
    mem_rd(1, 16'h0005, 8'h00, 0);
    op_a = 8'h7F;
    op_b = 8'h01;
    alu_en = 1'b1;
    tick();
    chk("status", status, 8'h2C);
    op_a = 8'hFF;
    alu_en = 1'b1;
    tick();
    chk("status", status, 8'h23);
    irq_req = 1'b1;
    #1 chk("grant", grant, 1'b0);
    tick();
    chk("sp", sp, 16'h04FF);
    ei = 1'b1;
    tick();
    chk("status", status, 8'hA3);
    irq_req = 1'b1;
    #1 chk("grant", grant, 1'b1);
    tick();
    chk("status", status, 8'h23);
    chk("sp", sp, 16'h04FD);
    // handler puts the saved flags back
    mem_wr(1, 16'h003F, 8'h23);
    sp_step(CFR_SP_IRQ_EXIT_OP, 16'h04FF);
    chk("status", status, 8'hA3);
    di = 1'b1;
    irq_req = 1'b1;
    #1 chk("grant", grant, 1'b0);
    tick();
    chk("status", status, 8'h23);
    sp_step(CFR_SP_PUSH, 16'h04FE);
    sp_step(CFR_SP_POP, 16'h04FF);
    sp_step(CFR_SP_CALL, 16'h04FD);
    sp_step(CFR_SP_RET, 16'h04FF);
    wb_kind = CFR_WB_B8;
    wb_sel = 5'h05;
    wb_data = 16'h00A5;
    sel_a = 5'h05;
    sel_b = 5'h05;
    tick();
    tick();
    chk("rd_a", rd_a, 8'hA5);
    chk("rd_b", rd_b, 8'hA5);
    bit_sel = 3'h2;
    t_in = 1'b1;
    tick();
    chk("status", status, 8'h63);
    bit_sel = 3'h1;
    t_out = 1'b1;
    tick();
    tick();
    chk("rd_a", rd_a, 8'hA7);
    wb_kind = CFR_WB_W16;
    wb_sel = 5'h1A;
    wb_data = 16'h1234;
    sel_a = 5'h1A;
    tick();
    tick();
    chk("rd_w", rd_w, 16'h1234);
    chk("rd_a", rd_a, 8'h34);
    ptr_req = 1'b1;
    ptr_disp = 6'h05;
    #1 chk("ptr", ptr_addr, 16'h1239);
    ptr_mode = CFR_PM_INC;
    #0.5 chk("ptr", ptr_addr, 16'h1234);
    tick();
    ptr_req = 1'b1;
    ptr_disp = 6'h00;
    #1 chk("ptr", ptr_addr, 16'h1235);
    ptr_mode = CFR_PM_DEC;
    #0.5 chk("ptr", ptr_addr, 16'h1234);
    tick();
    mem_rd(0, 16'h001A, 8'h34, 1);
    wb_kind = CFR_WB_W16;
    wb_sel = 5'h1C;
    wb_data = 16'h0102;
    tick();
    ptr_sel = 2'h1;
    #1 chk("ptr", ptr_addr, 16'h0102);
    wb_kind = CFR_WB_W16;
    wb_sel = 5'h1E;
    wb_data = 16'h0005;
    tick();
    ptr_req = 1'b1;
    ptr_sel = 2'h2;
    #1 chk("ptr", ptr_addr, 16'h0005);
    mem_wr(0, ptr_addr, 8'h3C);
    mem_rd(0, 16'h0005, 8'h3C, 1);
    mem_wr(0, 16'h005D, 8'h80);
    mem_wr(1, 16'h003E, 8'hFF);
    chk("sp", sp, 16'h0780);
    mem_rd(0, 16'h005E, 8'h07, 1);
    mem_rd(1, 16'h003D, 8'h80, 1);
    // clock enable low: a push and a status write must both be ignored
    ce = 1'b0;
    sp_op = CFR_SP_PUSH;
    mem_wr(0, 16'h005F, 8'hFF);
    chk("sp", sp, 16'h0780);
    chk("status", status, 8'h63);
    ce = 1'b1;
    sp_step(CFR_SP_PUSH, 16'h077F);
    finish_test();
  end
endmodule
